/* hw/bit_skip_call_clear_exec.sv */
// Executor for bit-test skips, subroutine call and clear instructions
// Functional notes
// - Skip-if-set discards next word when bit one
// - Skip-if-clear discards next word when bit zero
// - Clear file register zeroes it, sets zero
// - Clear accumulator zeroes it, sets zero
// - Call pushes program counter plus one
// - Call target low eleven, high from latch
// - Call takes two instruction cycles
// - Clear watchdog zeroes counter and prescaler
// - Clear watchdog sets expiry and powerdown
`timescale 1ns/100ps
`include "exec_consts.svh"
module bit_skip_call_clear_exec
  import exec_pkg::*;
#(
  parameter int STACK_DEPTH = `STACK_CAP
)(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire bus_req_t    bus_req,
  output logic [31:0]      bus_rdata,
  input  wire logic [13:0] fetch_word,
  output logic [12:0]      fetch_addr,
  output logic             instr_cycle,
  output logic [12:0]      stack_head,
  output logic             wdt_bite
);

  localparam logic [1:0] DIV_LAST  = 2'(`CYCLE_DIV - 1);
  localparam logic [2:0] SP_MASK   = 3'(STACK_DEPTH - 1);

  // Refuse settings the logic cannot serve
  if (STACK_DEPTH < 2 || STACK_DEPTH > `STACK_CAP || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0)
  begin : g_chk_depth
    $error("STACK_DEPTH must be a power of two from 2 to 8");
  end
  if (`CYCLE_DIV != 4)
  begin : g_chk_div
    $error("Instruction cycle must be four clocks");
  end
  if (`STACK_CAP != 8)
  begin : g_chk_cap
    $error("Return stack store must hold eight entries");
  end

  // Whole state lives in one registered struct
  state_t q;
  state_t d;

  // Operand fields of the offered word
  logic [6:0]  fidx;
  logic [2:0]  bsel;
  logic        bit_val;
  logic        file_hit;
  logic [6:0]  bus_idx;
  logic        op_skip_set;
  logic        op_skip_clr;
  logic        op_clr_file;
  logic        op_clr_acc;
  logic        op_call;
  logic        op_clr_wdt;

  // Pads a byte register into the read word
  function automatic logic [31:0] zext8(input logic [7:0] v);
    zext8 = {24'h00_0000, v};
  endfunction

  function automatic logic [12:0] pc_inc(input logic [12:0] pc);
    pc_inc = 13'(pc + 13'h0001);
  endfunction

  function automatic logic is_op(input logic [13:0] w, input logic [13:0] m, input logic [13:0] v);
    is_op = (w & m) == v;
  endfunction

  assign fidx     = fetch_word[6:0];
  assign bsel     = fetch_word[9:7];
  assign bit_val  = q.file[fidx][bsel];
  assign file_hit = (bus_req.addr[11:9] == `REG_FILE_SEL) && (bus_req.addr[1:0] == 2'b00);
  assign bus_idx  = bus_req.addr[8:2];

  // Opcode decode of the word offered in the slot
  assign op_skip_set = is_op(fetch_word, `OPC_SKIP_MASK, `OPC_SKIP_SET);
  assign op_skip_clr = is_op(fetch_word, `OPC_SKIP_MASK, `OPC_SKIP_CLR);
  assign op_clr_file = is_op(fetch_word, `OPC_CLR_MASK, `OPC_CLR_FILE);
  assign op_clr_acc  = is_op(fetch_word, `OPC_CLR_MASK, `OPC_CLR_ACC);
  assign op_call     = is_op(fetch_word, `OPC_CALL_MASK, `OPC_CALL);
  assign op_clr_wdt  = (fetch_word == `OPC_CLR_WDT);

  always_comb
  begin
    d          = q;
    d.rdata    = 32'h0000_0000;
    d.wdt_bite = 1'b0;
    // Divider: tick stands in the last clock of each slot
    d.div      = 2'(q.div + 2'b01);
    d.tick     = (q.div == 2'(DIV_LAST - 2'b01));

    // Register reads answer one cycle later
    if (bus_req.rd)
    begin
      if (file_hit)
      begin
        d.rdata = zext8(q.file[bus_idx]);
      end
      else
      begin
        unique case (bus_req.addr)
          `REG_STATUS:
          begin
            d.rdata[`ST_ZERO_BIT]  = q.zero_flag;
            d.rdata[`ST_PWRDN_BIT] = q.powerdown_flag;
            d.rdata[`ST_EXP_BIT]   = q.expiry_flag;
          end
          `REG_ACC:
          begin
            d.rdata = zext8(q.acc);
          end
          `REG_PC_LATCH:
          begin
            d.rdata = zext8(q.pc_high_latch);
          end
          `REG_PC:
          begin
            d.rdata = {19'h0_0000, q.pc};
          end
          `REG_WDT:
          begin
            d.rdata = {16'h0000, q.wdt_presc, q.wdt_cnt};
          end
          `REG_CTRL:
          begin
            d.rdata[`CTRL_WDT_EN_BIT] = q.wdt_en;
          end
          `REG_STACK:
          begin
            d.rdata = {13'h0000, q.stack_head, 3'h0, q.sp};
          end
          default:
          begin
            d.rdata = 32'h0000_0000;
          end
        endcase
      end
    end

    // Register writes, overridden below by instruction effects
    if (bus_req.wr)
    begin
      if (file_hit)
      begin
        d.file[bus_idx] = bus_req.wdata[7:0];
      end
      else
      begin
        unique case (bus_req.addr)
          `REG_STATUS:
          begin
            d.zero_flag = bus_req.wdata[`ST_ZERO_BIT];
          end
          `REG_ACC:
          begin
            d.acc = bus_req.wdata[7:0];
          end
          `REG_PC_LATCH:
          begin
            d.pc_high_latch = bus_req.wdata[7:0];
          end
          `REG_CTRL:
          begin
            d.wdt_en = bus_req.wdata[`CTRL_WDT_EN_BIT];
          end
          default:
          begin
            d.wdt_en = q.wdt_en;
          end
        endcase
      end
    end

    // Instruction effects come last so they win over bus writes
    if (q.tick)
    begin
      // Watchdog advances once per instruction cycle
      if (q.wdt_en)
      begin
        d.wdt_presc = 8'(q.wdt_presc + 8'h01);
        if (q.wdt_presc == 8'hff)
        begin
          d.wdt_cnt = 8'(q.wdt_cnt + 8'h01);
          if (q.wdt_cnt == 8'hff)
          begin
            d.expiry_flag = 1'b0;
            d.wdt_bite    = 1'b1;
          end
        end
      end

      // Sequencer: execute, discard a skipped word, or hold in call slot two
      unique case (q.seq)
        SEQ_EXEC:
        begin
          d.pc = pc_inc(q.pc);
          if (op_skip_set)
          begin
            if (bit_val)
            begin
              d.seq = SEQ_SKIP;
            end
          end
          else if (op_skip_clr)
          begin
            if (!bit_val)
            begin
              d.seq = SEQ_SKIP;
            end
          end
          else if (op_clr_file)
          begin
            d.file[fidx] = 8'h00;
            d.zero_flag  = 1'b1;
          end
          else if (op_clr_acc)
          begin
            d.acc       = 8'h00;
            d.zero_flag = 1'b1;
          end
          else if (op_call)
          begin
            d.stack[q.sp] = pc_inc(q.pc);
            d.stack_head  = pc_inc(q.pc);
            d.sp          = (q.sp + 3'h1) & SP_MASK;
            d.pc = {q.pc_high_latch[`PLH_LO_BIT+1:`PLH_LO_BIT], fetch_word[10:0]};
            d.seq = SEQ_CALL;
          end
          else if (op_clr_wdt)
          begin
            d.wdt_cnt   = 8'h00;
            d.wdt_presc = 8'h00;
            d.wdt_bite  = 1'b0;
            d.expiry_flag    = 1'b1;
            d.powerdown_flag = 1'b1;
          end
          else
          begin
            // Other words act as no_operation
            d.seq = SEQ_EXEC;
          end
        end
        SEQ_SKIP:
        begin
          d.pc  = pc_inc(q.pc);
          d.seq = SEQ_EXEC;
        end
        SEQ_CALL:
        begin
          d.seq = SEQ_EXEC;
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      q                <= '0;
      q.expiry_flag    <= `RST_EXP;
      q.powerdown_flag <= `RST_PWRDN;
      q.wdt_en         <= `RST_WDT_EN;
      q.seq            <= SEQ_EXEC;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs come straight from state flops
  assign bus_rdata   = q.rdata;
  assign fetch_addr  = q.pc;
  assign instr_cycle = q.tick;
  assign stack_head  = q.stack_head;
  assign wdt_bite    = q.wdt_bite;

endmodule // bit_skip_call_clear_exec

/* hw/exec_consts.svh */
// Constants for the bit-test, skip, call and clear executor
`ifndef EXEC_CONSTS_SVH
`define EXEC_CONSTS_SVH
`define MCLK_PERIOD_NS    10
`define CYCLE_PERIOD_NS   40
`define CYCLE_DIV         (`CYCLE_PERIOD_NS / `MCLK_PERIOD_NS)
`define STACK_CAP         8
`define OPC_SKIP_MASK     14'h3c00
`define OPC_SKIP_SET      14'h1c00
`define OPC_SKIP_CLR      14'h1800
`define OPC_CLR_MASK      14'h3f80
`define OPC_CLR_FILE      14'h0180
`define OPC_CLR_ACC       14'h0100
`define OPC_CALL_MASK     14'h3800
`define OPC_CALL          14'h2000
`define OPC_CLR_WDT       14'h0064
`define REG_STATUS        12'h000
`define REG_ACC           12'h004
`define REG_PC_LATCH      12'h008
`define REG_PC            12'h00c
`define REG_WDT           12'h010
`define REG_CTRL          12'h014
`define REG_STACK         12'h018
`define REG_FILE_SEL      3'h1
`define ST_ZERO_BIT       0
`define ST_PWRDN_BIT      3
`define ST_EXP_BIT        4
`define CTRL_WDT_EN_BIT   0
`define PLH_LO_BIT        3
`define RST_EXP           1'b1
`define RST_PWRDN         1'b1
`define RST_WDT_EN        1'b0
`endif

/* hw/exec_pkg.sv */
// Types for the bit-test, skip, call and clear executor
package exec_pkg;
  typedef enum logic [1:0] {SEQ_EXEC, SEQ_SKIP, SEQ_CALL} seq_t;
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;
  typedef struct packed {
    logic [127:0][7:0] file;
    logic [7:0]        acc;
    logic              zero_flag;
    logic              expiry_flag;
    logic              powerdown_flag;
    logic [7:0]        pc_high_latch;
    logic [12:0]       pc;
    logic [7:0][12:0]  stack;
    logic [2:0]        sp;
    logic [12:0]       stack_head;
    logic [7:0]        wdt_cnt;
    logic [7:0]        wdt_presc;
    logic              wdt_en;
    logic              wdt_bite;
    logic [1:0]        div;
    logic              tick;
    seq_t              seq;
    logic [31:0]       rdata;
  } state_t;
endpackage

/* tb/bit_skip_call_clear_exec_monitor.sv */
// Port-level assertion checker for the executor
`timescale 1ns/100ps
`include "exec_consts.svh"
module exec_monitor
  import exec_pkg::*;
(
  input wire logic        mclk,
  input wire logic        resetn,
  input wire bus_req_t    bus_req,
  input wire logic [31:0] bus_rdata,
  input wire logic [13:0] fetch_word,
  input wire logic [12:0] fetch_addr,
  input wire logic        instr_cycle,
  input wire logic [12:0] stack_head,
  input wire logic        wdt_bite
);
  logic call_pend_q;
  logic call_ex;
  assign call_ex = instr_cycle && !call_pend_q && ((fetch_word & `OPC_CALL_MASK) == `OPC_CALL);
  // Second call slot tracker
  always_ff @(posedge mclk)
  begin
    if (!resetn) call_pend_q <= 1'b0;
    else if (instr_cycle) call_pend_q <= call_ex;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_slot_spacing: assert property (instr_cycle |=> !instr_cycle [*3] ##1 instr_cycle)
    else $error("slot spacing wrong");
  a_call_target_low: assert property (call_ex |=> fetch_addr[10:0] == $past(fetch_word[10:0]))
    else $error("call target wrong");
  a_call_push_ret: assert property (call_ex |=> stack_head == $past(fetch_addr) + 13'h0001)
    else $error("return address wrong");
  a_call_holds_pc: assert property (call_ex |=> ##1 $stable(fetch_addr) [*4])
    else $error("call second slot moved pc");
  a_plain_advance: assert property (instr_cycle && !call_pend_q && !call_ex |=>
    fetch_addr == $past(fetch_addr) + 13'h0001)
    else $error("pc did not step by one");
  a_addr_slot_only: assert property ($changed(fetch_addr) |-> $past(instr_cycle))
    else $error("pc moved outside slot");
  a_read_one_cycle: assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0000_0000)
    else $error("read data outside window");
  a_bite_pulse: assert property (wdt_bite |=> !wdt_bite)
    else $error("bite longer than one cycle");
  c_call: cover property (call_ex);
  c_skip: cover property (instr_cycle && fetch_word[13:11] == 3'b011);
  c_read: cover property (bus_req.rd);
endmodule // exec_monitor

bind bit_skip_call_clear_exec exec_monitor exec_monitor_i (.mclk(mclk), .resetn(resetn), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .fetch_word(fetch_word), .fetch_addr(fetch_addr), .instr_cycle(instr_cycle),
  .stack_head(stack_head), .wdt_bite(wdt_bite));

/* tb/tb_bit_skip_call_clear_exec.sv */
// Self-checking bench for the executor
`timescale 1ns/100ps
module tb_bit_skip_call_clear_exec
  import exec_pkg::*;
;
  logic        mclk, resetn, instr_cycle, wdt_bite, rd_pend;
  bus_req_t    bus_req;
  logic [31:0] bus_rdata, rnd;
  logic [13:0] fetch_word;
  logic [12:0] fetch_addr, stack_head;
  logic [13:0] prog [0:8191];
  logic [31:0] vals [6:9];
  logic [31:0] exp_q [$];
  int          fail_count, tests_run, bite_seen;
  bit_skip_call_clear_exec bit_skip_call_clear_exec_i (.mclk(mclk), .resetn(resetn), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .fetch_word(fetch_word), .fetch_addr(fetch_addr), .instr_cycle(instr_cycle),
    .stack_head(stack_head), .wdt_bite(wdt_bite));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus_req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge mclk);
  endtask
  // Program memory and read-data watcher
  always @(posedge mclk)
  begin
    fetch_word <= prog[fetch_addr];
    if (rd_pend) check("read data", bus_rdata, exp_q.pop_front());
    rd_pend <= bus_req.rd;
    if (wdt_bite) bite_seen++;
  end
  // Watchdog: program needs about 120 clocks
  initial
  begin
    repeat (3000) @(posedge mclk);
    fail_count++;
    end_sim;
  end
  initial
  begin
    resetn = 1'b0;
    bus_req = '0;
    fail_count = 0;
    tests_run = 0;
    rnd = 32'h0000_53cc;
    foreach (prog[i]) prog[i] = 14'h0000;
    prog[8] = 14'h1c05;
    prog[9] = 14'h0186;
    prog[10] = 14'h1885;
    prog[11] = 14'h0187;
    prog[12] = 14'h1c85;
    prog[13] = 14'h0188;
    prog[14] = 14'h1905;
    prog[15] = 14'h0100;
    prog[16] = 14'h27f0;
    prog[13'h1ff0] = 14'h0064;
    prog[13'h1ff1] = 14'h27f1;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    wr(12'h008, 32'h0000_0018);
    wr(12'h214, 32'h0000_00a5);
    wr(12'h014, 32'h0000_0001);
    wr(12'h004, 32'h0000_005a);
    for (int f = 6; f < 10; f++)
    begin
      rnd = xs(rnd);
      vals[f] = {24'h00_0000, rnd[7:1], 1'b1};
      wr(12'h200 + 12'(4 * f), vals[f]);
    end
    wr(12'h100, 32'h0000_00ff);
    rd(12'h100, 32'h0000_0000);
    bus_req <= '0;
    for (int n = 0; n < 400 && !(instr_cycle && fetch_addr == 13'h1ff0); n++) @(posedge mclk);
    check("slot at clear watchdog", {19'h0_0000, fetch_addr}, 32'h0000_1ff0);
    wr(12'h014, 32'h0000_0000);
    bus_req <= '0;
    repeat (20) @(posedge mclk);
    rd(12'h010, 32'h0000_0000);
    rd(12'h000, 32'h0000_0019);
    rd(12'h004, 32'h0000_0000);
    for (int f = 6; f < 10; f++) rd(12'h200 + 12'(4 * f), (f == 8) ? 32'h0000_0000 : vals[f]);
    bus_req <= '0;
    repeat (2) @(posedge mclk);
    check("return address", {19'h0_0000, stack_head}, 32'h0000_1ff2);
    check("program counter", {19'h0_0000, fetch_addr}, 32'h0000_1ff1);
    check("watchdog bite", 32'(bite_seen), 32'h0000_0000);
    end_sim;
  end
endmodule // tb_bit_skip_call_clear_exec
